// [hw/fap_flash_access.sv]
// Flash access front end: protection, ECC, status and AXI4-Lite registers
//
// The AXI4-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module fap_flash_access
  import fap_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // AXI4-Lite register slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Flash access from processor or debug port
  input fap_acc_req_t acc_req,
  output fap_acc_rsp_t acc_rsp,
  // Flash array
  output logic fl_en,
  output logic fl_we,
  output logic fl_information_pages,
  output logic [14:0] fl_addr,
  output logic [38:0] fl_wdata,
  input wire logic [38:0] fl_rdata,
  // Command engine
  output logic cmd_start,
  output logic [7:0] cmd_code,
  output logic [7:0] cmd_page,
  input wire logic cmd_done,
  input wire logic [2:0] allow_set,
  // System memory information
  input wire logic [31:0] sys_mem_information_pages,
  // Interrupts
  output logic irq,
  output logic nmi_fetch_empty,
  output logic nmi_fetch_uncorr
);

  // ******************************************************
  // Declarations
  // ******************************************************
  logic aw_held_reg, w_held_reg, bvalid_reg, rvalid_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg, rdata_reg, acc_rdata_reg, mem_information_pages_reg;
  logic [3:0] w_strb_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [7:0] core_reg, core_next, irq_en_reg, irq_en_next;
  logic [2:0] fetch_st_reg, fetch_st_next, load_st_reg, load_st_next;
  logic [15:0] fetch_adr_reg, load_adr_reg;
  fap_state_t state_reg;
  logic [4:0] cnt_reg;
  logic acc_err_reg, op_fetch_reg, op_write_reg;
  logic cmd_start_reg;
  logic [7:0] cmd_code_reg, cmd_page_reg;

  function automatic logic reg_mapped(input logic [7:0] a);
    return (a[1:0] == 2'b00) && (int'(a[7:2]) <= REG_LAST_IDX);
  endfunction

  // ******************************************************
  // AXI4-Lite slave
  // ******************************************************
  // Address and data may arrive in either order; both are held first
  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready = !w_held_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;
  wire aw_fire = s_axi_awvalid && s_axi_awready;
  wire w_fire = s_axi_wvalid && s_axi_wready;
  wire ar_fire = s_axi_arvalid && s_axi_arready;
  wire wr_do = aw_held_reg && w_held_reg;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
    end else begin
      if (aw_fire) aw_held_reg <= 1'b1;
      if (aw_fire) aw_addr_reg <= s_axi_awaddr;
      if (w_fire) w_held_reg <= 1'b1;
      if (w_fire) w_data_reg <= s_axi_wdata;
      if (w_fire) w_strb_reg <= s_axi_wstrb;
      if (wr_do) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= reg_mapped(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Write strobes of each register; execute takes any size, the enable byte and the clear bit need their byte lane strobed
  wire we_core = wr_do && (aw_addr_reg == REG_CORE);
  wire we_irq = wr_do && (aw_addr_reg == REG_IRQ_EN) && w_strb_reg[0];
  wire we_exec = wr_do && (aw_addr_reg == REG_EXEC);
  // Writing one to this bit re-arms protection
  wire clr_allow = we_core && w_data_reg[CLR_ALLOW_BIT] && w_strb_reg[1];

  // Read side effects happen at the address handshake
  wire rd_core = ar_fire && (s_axi_araddr == REG_CORE);
  wire rd_fetch = ar_fire && (s_axi_araddr == REG_FETCH_ST);
  wire rd_load = ar_fire && (s_axi_araddr == REG_LOAD_ST);
  wire [31:0] rd_mux =
    (s_axi_araddr == REG_CORE) ? {24'h000000, core_reg} :
    (s_axi_araddr == REG_IRQ_EN) ? {24'h000000, irq_en_reg} :
    (s_axi_araddr == REG_FETCH_ST) ? {29'h00000000, fetch_st_reg} :
    (s_axi_araddr == REG_FETCH_ADR) ? {16'h0000, fetch_adr_reg} :
    (s_axi_araddr == REG_LOAD_ST) ? {29'h00000000, load_st_reg} :
    (s_axi_araddr == REG_LOAD_ADR) ? {16'h0000, load_adr_reg} :
    (s_axi_araddr == REG_MEMINFO) ? mem_information_pages_reg :
    32'h00000000;

  // Register reads are never refused, from either master
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= 32'h00000000;
    end else if (ar_fire) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_mux;
      rresp_reg <= reg_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ******************************************************
  // Protection checks
  // ******************************************************
  // Protection field copied from the system each cycle
  wire [1:0] prot = mem_information_pages_reg[PROT_PERM:PROT_KEY];
  wire lock = |prot;
  wire [2:0] allow = core_reg[CORE_ALLOW +: 3];
  wire [1:0] acc_sec = sect_of(acc_req.addr[14:7], mem_information_pages_reg[7:0],
                               mem_information_pages_reg[15:8]);
  wire in_range = acc_req.addr < MAIN_WORDS;
  // Top quarter of the information_pages pages holds the unlock key
  wire information_pages_key = acc_req.addr[8:7] == 2'b11;
  // Allow flags left set keep locked code readable
  wire rd_ok = acc_req.information_pages ? (!information_pages_key || !lock)
             : (in_range && (!acc_req.jtag || !lock || |allow));
  // Size is ignored on reads; the whole word is returned
  wire wr_ok = !acc_req.information_pages && in_range
             && (acc_req.size == SZ_WORD)
             && (!lock || (!acc_req.jtag && acc_sec == SEC_LOG));
  wire acc_ok = acc_req.write ? wr_ok : rd_ok;
  wire acc_start = (state_reg == S_IDLE) && acc_req.valid;

  // ******************************************************
  // Flash access sequencer
  // ******************************************************
  // ECC check bits and overall parity added to every word
  wire [5:0] wr_chk = ecc_syn(acc_req.wdata);
  wire [38:0] wr_word = {^{wr_chk, acc_req.wdata}, wr_chk, acc_req.wdata};
  wire [5:0] rd_syn = ecc_syn(fl_rdata[31:0]) ^ fl_rdata[37:32];
  wire rd_empty = &fl_rdata;
  wire rd_corr = !rd_empty && (^fl_rdata);
  wire rd_unc = !rd_empty && !(^fl_rdata) && (rd_syn != 6'h00);
  wire [31:0] rd_data = rd_corr ? ecc_fix(fl_rdata[31:0], rd_syn)
                                : fl_rdata[31:0];
  wire rd_finish = (state_reg == S_RUN) && (cnt_reg == 5'h00) && !op_write_reg;
  wire [2:0] rd_ev = {rd_unc, rd_empty, rd_corr};
  wire [2:0] ev_fetch = (rd_finish && op_fetch_reg) ? rd_ev : 3'h0;
  wire [2:0] ev_load = (rd_finish && !op_fetch_reg) ? rd_ev : 3'h0;

  // The array is held enabled for the full access time
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= S_IDLE;
      cnt_reg <= 5'h00;
      fl_en <= 1'b0;
      fl_we <= 1'b0;
      fl_information_pages <= 1'b0;
      fl_addr <= 15'h0000;
      fl_wdata <= 39'h0000000000;
      acc_err_reg <= 1'b0;
      acc_rdata_reg <= 32'h00000000;
      op_fetch_reg <= 1'b0;
      op_write_reg <= 1'b0;
    end else begin
      case (state_reg)
        S_IDLE: begin
          if (acc_start && acc_ok) begin
            fl_en <= 1'b1;
            fl_we <= acc_req.write;
            fl_information_pages <= acc_req.information_pages;
            fl_addr <= acc_req.addr;
            fl_wdata <= wr_word;
            cnt_reg <= acc_req.write ? FL_WR_LOAD : FL_RD_LOAD;
            op_fetch_reg <= acc_req.fetch && !acc_req.jtag;
            op_write_reg <= acc_req.write;
            acc_err_reg <= 1'b0;
            state_reg <= S_RUN;
          end else if (acc_start) begin
            // Refused: array untouched, no data exposed
            acc_err_reg <= 1'b1;
            acc_rdata_reg <= 32'h00000000;
            state_reg <= S_RESP;
          end
        end
        S_RUN: begin
          if (cnt_reg == 5'h00) begin
            fl_en <= 1'b0;
            fl_we <= 1'b0;
            acc_rdata_reg <= op_write_reg ? 32'h00000000 : rd_data;
            acc_err_reg <= rd_unc && !op_write_reg;
            state_reg <= S_RESP;
          end else begin
            cnt_reg <= cnt_reg - 5'h01;
          end
        end
        S_RESP: state_reg <= S_IDLE;
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  assign acc_rsp = '{done: state_reg == S_RESP, err: acc_err_reg,
                     rdata: acc_rdata_reg};

  // ******************************************************
  // Read error status
  // ******************************************************
  // A new error loads only into an empty or just-read register, so the
  // first address survives and a read never swallows an arriving error
  wire ld_fetch = (ev_fetch != 3'h0) && ((fetch_st_reg == 3'h0) || rd_fetch);
  wire ld_load = (ev_load != 3'h0) && ((load_st_reg == 3'h0) || rd_load);
  assign fetch_st_next = ld_fetch ? ev_fetch
                       : (rd_fetch ? 3'h0 : fetch_st_reg);
  assign load_st_next = ld_load ? ev_load
                      : (rd_load ? 3'h0 : load_st_reg);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      fetch_st_reg <= 3'h0;
      load_st_reg <= 3'h0;
      fetch_adr_reg <= 16'h0000;
      load_adr_reg <= 16'h0000;
    end else begin
      fetch_st_reg <= fetch_st_next;
      load_st_reg <= load_st_next;
      if (ld_fetch) fetch_adr_reg <= {fl_information_pages, fl_addr};
      if (ld_load) load_adr_reg <= {fl_information_pages, fl_addr};
    end
  end

  // ******************************************************
  // Commands and core status
  // ******************************************************
  // Setup order is free; the execute write alone launches
  wire [1:0] cmd_sec = sect_of(w_data_reg[15:8], mem_information_pages_reg[7:0],
                               mem_information_pages_reg[15:8]);
  wire cmd_ok = cmd_allowed(w_data_reg[7:0], cmd_sec, prot, allow)
              && !core_reg[CORE_BUSY];
  wire cmd_go = we_exec && cmd_ok;
  wire acc_rej = (state_reg == S_IDLE) && acc_req.valid && !acc_ok;
  wire [3:0] core_ev = {acc_rej && !acc_req.write, acc_rej && acc_req.write,
                        we_exec && !cmd_ok, cmd_done};
  // Clear-on-read flags lose to a same-cycle event
  assign core_next[3:0] = (core_reg[3:0] & ~{4{rd_core}}) | core_ev;
  assign core_next[CORE_BUSY] = cmd_go || (core_reg[CORE_BUSY] && !cmd_done);
  assign core_next[7:5] = (allow & ~{3{clr_allow}}) | allow_set;
  // Only the enable byte is kept; upper bits read zero
  assign irq_en_next = we_irq ? w_data_reg[7:0] : irq_en_reg;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      core_reg <= 8'h00;
      irq_en_reg <= 8'h00;
      mem_information_pages_reg <= MEMINFO_RESET;
      cmd_start_reg <= 1'b0;
      cmd_code_reg <= 8'h00;
      cmd_page_reg <= 8'h00;
    end else begin
      core_reg <= core_next;
      irq_en_reg <= irq_en_next;
      mem_information_pages_reg <= sys_mem_information_pages & MEMINFO_MASK;
      cmd_start_reg <= cmd_go;
      if (cmd_go) cmd_code_reg <= w_data_reg[7:0];
      if (cmd_go) cmd_page_reg <= w_data_reg[15:8];
    end
  end

  assign cmd_start = cmd_start_reg;
  assign cmd_code = cmd_code_reg;
  assign cmd_page = cmd_page_reg;

  // ******************************************************
  // Interrupt outputs
  // ******************************************************
  // Fetch-side empty and uncorrectable are too severe to be masked
  wire [7:0] irq_src = {fetch_st_reg[ERR_CORR], load_st_reg[ERR_UNC],
                        load_st_reg[ERR_EMPTY], load_st_reg[ERR_CORR],
                        core_reg[3:0]};
  assign irq = |(irq_src & irq_en_reg);
  assign nmi_fetch_empty = fetch_st_reg[ERR_EMPTY];
  assign nmi_fetch_uncorr = fetch_st_reg[ERR_UNC];

  // ******************************************************
  // Assertions
  // ******************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  irq_fall_cause_a: assert property (
    $fell(irq) |-> $past(rd_core || rd_fetch || rd_load || we_irq))
    else $error("interrupt dropped without a clear or mask write");
  irq_assert_a: assert property (
    ld_load && ev_load[ERR_EMPTY] && irq_en_reg[5] && !we_irq |=> irq)
    else $error("enabled empty load flag did not raise interrupt");
  nmi_fetch_a: assert property (
    (ev_fetch[ERR_UNC] && fetch_st_reg == 3'h0) |=> nmi_fetch_uncorr)
    else $error("uncorrectable fetch did not raise non-maskable");
  jtag_lock_a: assert property (
    acc_start && acc_req.jtag && !acc_req.information_pages && !acc_req.write
    && lock && allow == 3'h0 |=> acc_rsp.done && acc_rsp.err && !fl_en)
    else $error("locked debug read was not refused");
  information_pages_write_a: assert property (
    acc_start && acc_req.write && acc_req.information_pages |=> !fl_we ##0 acc_rsp.err)
    else $error("information_pages page write reached the array");
  word_write_a: assert property (
    $rose(fl_we) |-> $past(acc_req.size) == SZ_WORD)
    else $error("main write issued with narrow size");
  first_addr_a: assert property (
    (fetch_st_reg != 3'h0) && !rd_fetch |=> $stable(fetch_adr_reg))
    else $error("first error address overwritten");
  one_flag_a: assert property (
    $onehot0(fetch_st_reg) && $onehot0(load_st_reg))
    else $error("more than one error type flag set");
  allow_clear_a: assert property (
    clr_allow && allow_set == 3'h0 |=> core_reg[7:5] == 3'h0)
    else $error("allow flags not cleared");
  cmd_refuse_a: assert property (
    we_exec && !cmd_ok |=> !cmd_start && core_reg[CORE_REFUSE])
    else $error("forbidden command was launched");
  read_time_a: assert property (
    $rose(fl_en) && !fl_we |-> fl_en [*8] ##1 !fl_en)
    else $error("read access time not held");
  reject_data_a: assert property (
    acc_rsp.done && acc_rsp.err && $past(state_reg) == S_IDLE
    |-> acc_rsp.rdata == 32'h00000000)
    else $error("refused read exposed data");

  corr_read_c: cover property (ld_load && ev_load[ERR_CORR] ##[1:20] rd_load);
  jtag_rej_c: cover property (acc_rej && acc_req.jtag);
  cmd_run_c: cover property (cmd_start ##[1:200] core_reg[CORE_DONE]);

endmodule // fap_flash_access

// [include/fap_pkg.sv]
// Constants, types and helper functions of the flash access front end
//
// Contract
// - One active-high maskable interrupt, processor line zero
// - Two non-maskable sources, independent of enables
// - Processor main reads always; debug port only unlocked or with an allow flag set
// - Lower information_pages quarters and registers always readable
// - Upper information_pages quarter readable only without protection
// - Reads accept byte, half-word and word sizes
// - Information_pages writes refused; register writes always accepted
// - Unprotected: whole main area writable by both
// - Protected: only processor writes to log section
// - Main-area writes accepted only at word size
// - Commands from both; refused when protection forbids
// - Separate read-error status for fetches and loads
// - Corrected error flag, clear on read, maskable
// - Empty flag; load side maskable, fetch side non-maskable
// - Uncorrectable flag; load maskable, fetch non-maskable
// - First failing address held until status read
// - One error type flag at most, no count
// - Eight core flags; four clear on read, maskable
// - Allow flags read-only; clear bit resets them
// - Set allow flags permit reading locked contents
// - ECC generated, checked; access timing enforced internally
// - Protection field: key lock, permanent lock, fail count
package fap_pkg;

  // ******************************************************
  // Register map and fields
  // ******************************************************
  localparam logic [7:0] REG_CORE = 8'h00;
  localparam logic [7:0] REG_IRQ_EN = 8'h04;
  localparam logic [7:0] REG_FETCH_ST = 8'h08;
  localparam logic [7:0] REG_FETCH_ADR = 8'h0C;
  localparam logic [7:0] REG_LOAD_ST = 8'h10;
  localparam logic [7:0] REG_LOAD_ADR = 8'h14;
  localparam logic [7:0] REG_MEMINFO = 8'h18;
  localparam logic [7:0] REG_EXEC = 8'h1C;
  localparam int REG_LAST_IDX = 7;
  localparam int CORE_DONE = 0;
  localparam int CORE_REFUSE = 1;
  localparam int CORE_WREJ = 2;
  localparam int CORE_RREJ = 3;
  localparam int CORE_BUSY = 4;
  localparam int CORE_ALLOW = 5;
  localparam int CLR_ALLOW_BIT = 8;
  localparam int ALLOW_KEY = 0;
  localparam int ALLOW_BOOT = 1;
  localparam int ALLOW_PROG = 2;
  localparam int ERR_CORR = 0;
  localparam int ERR_EMPTY = 1;
  localparam int ERR_UNC = 2;
  localparam int PROT_KEY = 28;
  localparam int PROT_PERM = 29;
  localparam logic [31:0] MEMINFO_RESET = 32'hF7FFFFFF;
  localparam logic [31:0] MEMINFO_MASK = 32'hF7FFFFFF;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ******************************************************
  // Flash geometry, sizes, sections, commands, timing
  // ******************************************************
  localparam int MAIN_AW = 15;
  localparam logic [14:0] MAIN_WORDS = 15'h6000;
  localparam int CW_POS = 38;
  localparam logic [1:0] SZ_WORD = 2'b10;
  localparam logic [1:0] SEC_BOOT = 2'b00;
  localparam logic [1:0] SEC_PROG = 2'b01;
  localparam logic [1:0] SEC_LOG = 2'b10;
  localparam logic [7:0] CMD_ERASE_MAIN = 8'h00;
  localparam logic [7:0] CMD_ERASE_BOOT_PROG = 8'h02;
  localparam logic [7:0] CMD_ERASE_PROG = 8'h03;
  localparam logic [7:0] CMD_ERASE_PAGE = 8'h04;
  localparam logic [7:0] CMD_ERASE_KEY = 8'h06;
  localparam logic [7:0] CMD_UNLOCK = 8'h08;
  localparam logic [7:0] CMD_GETENV = 8'h09;
  localparam logic [7:0] CMD_WRITE = 8'h0A;
  localparam logic [7:0] CMD_SET_KEY = 8'h0C;
  localparam logic [7:0] CMD_SET_BOUNDARY = 8'h0D;
  localparam int CLK_MHZ = 200;
  localparam int FL_RD_NS = 40;
  localparam int FL_WR_NS = 100;
  localparam int FL_RD_CYC = (FL_RD_NS * CLK_MHZ + 999) / 1000;
  localparam int FL_WR_CYC = (FL_WR_NS * CLK_MHZ + 999) / 1000;
  localparam logic [4:0] FL_RD_LOAD = 5'(FL_RD_CYC - 1);
  localparam logic [4:0] FL_WR_LOAD = 5'(FL_WR_CYC - 1);

  // ******************************************************
  // Types
  // ******************************************************
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_RUN = 2'b01,
    S_RESP = 2'b10
  } fap_state_t;

  typedef struct packed {
    logic valid;
    logic jtag;
    logic fetch;
    logic write;
    logic information_pages;
    logic [1:0] size;
    logic [14:0] addr;
    logic [31:0] wdata;
  } fap_acc_req_t;

  typedef struct packed {
    logic done;
    logic err;
    logic [31:0] rdata;
  } fap_acc_rsp_t;

  // ******************************************************
  // Functions
  // ******************************************************
  // Hamming syndrome of the data bits at non-power-of-two positions
  function automatic logic [5:0] ecc_syn(input logic [31:0] d);
    logic [5:0] s;
    int k;
    s = 6'h00;
    k = 0;
    for (int p = 1; p <= CW_POS; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (d[k]) s = s ^ 6'(p);
        k = k + 1;
      end
    end
    return s;
  endfunction

  // Flip the data bit that the syndrome points at
  function automatic logic [31:0] ecc_fix(input logic [31:0] d,
                                          input logic [5:0] s);
    logic [31:0] r;
    int k;
    r = d;
    k = 0;
    for (int p = 1; p <= CW_POS; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (s == 6'(p)) r[k] = ~r[k];
        k = k + 1;
      end
    end
    return r;
  endfunction

  // Section of a main-area page from the boundary pages
  function automatic logic [1:0] sect_of(input logic [7:0] page,
                                         input logic [7:0] prog_start,
                                         input logic [7:0] log_start);
    if (page >= log_start) return SEC_LOG;
    if (page >= prog_start) return SEC_PROG;
    return SEC_BOOT;
  endfunction

  // Whether protection lets a command run
  function automatic logic cmd_allowed(input logic [7:0] code,
                                       input logic [1:0] sec,
                                       input logic [1:0] prot,
                                       input logic [2:0] allow);
    logic lock;
    lock = |prot;
    case (code)
      CMD_ERASE_MAIN, CMD_ERASE_BOOT_PROG, CMD_ERASE_PROG,
      CMD_GETENV: return 1'b1;
      CMD_ERASE_PAGE: return (sec == SEC_LOG) || !lock;
      CMD_ERASE_KEY: return !lock || allow[ALLOW_KEY];
      CMD_UNLOCK: return prot[0] && !prot[1];
      CMD_WRITE: return (sec == SEC_LOG) || !lock ||
        ((sec == SEC_BOOT) ? allow[ALLOW_BOOT] : allow[ALLOW_PROG]);
      CMD_SET_KEY, CMD_SET_BOUNDARY: return !lock;
      default: return 1'b0;
    endcase
  endfunction

endpackage

// [testbench/fap_flash_access_tb.sv]
// Self-checking bench of the flash access front end
`timescale 1ns/1ps
module fap_flash_access_tb;
  import fap_pkg::*;
  logic clk_sys = 0, reset_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, irq, nmi_fetch_empty, nmi_fetch_uncorr, fl_en, fl_we;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, sys_mem_information_pages = 0, mi;
  logic [3:0] s_axi_wstrb = 0;
  logic [2:0] allow_set = 0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [38:0] fl_wdata, fl_rdata, flip = 0;
  logic [14:0] fl_addr;
  logic cmd_done = 0, cmd_start;
  logic [7:0] cmd_code, cmd_page;
  fap_acc_req_t acc_req = '0;
  fap_acc_rsp_t acc_rsp;
  int err_count = 0, checks_done = 0, seed = 63361, starts = 0;
  logic [31:0] ref_mem [int];
  always #2.5 clk_sys = ~clk_sys;
  fap_flash_access u_dut (.*, .fl_information_pages());
  // Launch pulses counted mid-cycle, where they are settled
  always @(negedge clk_sys) if (cmd_start === 1'b1) starts++;
  fap_flash_model u_fl (.clk_sys, .fl_en, .fl_we, .fl_addr, .fl_wdata, .flip,
    .fl_rdata);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Address and data offered together, each dropped once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    bit ao = 1, wo = 1;
    @(posedge clk_sys);
    s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1; s_axi_wvalid <= 1;
    while (ao || wo) begin
      @(posedge clk_sys);
      if (s_axi_awready) ao = 0;
      if (s_axi_wready) wo = 0;
      s_axi_awvalid <= ao; s_axi_wvalid <= wo; s_axi_bready <= !ao && !wo;
    end
    do @(posedge clk_sys); while (!s_axi_bvalid);
    s_axi_bready <= 0;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] v,
    output logic [1:0] rs);
    @(posedge clk_sys);
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    do @(posedge clk_sys); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge clk_sys); while (!s_axi_rvalid);
    v = s_axi_rdata; rs = s_axi_rresp; s_axi_rready <= 0;
  endtask
  // Valid drops at the edge that ends the done cycle, before a re-take
  task automatic acc(input logic [4:0] k, input logic [1:0] sz, input int ad,
    input logic [31:0] v, output logic e, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_sys);
    acc_req <= '{1'b1, k[4], k[3], k[2], k[1], sz, 15'(ad), v};
    do begin
      @(posedge clk_sys);
      n++;
    end while (acc_rsp.done !== 1'b1 && n < 40);
    chk(acc_rsp.done, 1'b1);
    acc_req.valid <= 1'b0;
    e = acc_rsp.err; r = acc_rsp.rdata;
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #200000 err_count++;
    test_done();
  end
  initial begin
    logic e; logic [31:0] r; logic [1:0] rs;
    sys_mem_information_pages = $random(seed);
    mi = sys_mem_information_pages;
    repeat (16) @(posedge clk_sys);
    reset_n <= 1;
    axr(REG_MEMINFO, r, rs); chk(r, mi & MEMINFO_MASK);
    sys_mem_information_pages <= 0;
    axr(8'h20, r, rs); chk(rs, RESP_SLVERR);
    // Erased-only, word-size writes then debug read back
    for (int i = 0; i < 4; i++) begin
      ref_mem[i] = $random(seed);
      acc(5'h04, SZ_WORD, i, ref_mem[i], e, r); chk(e, 1'b0);
      acc(5'h10, SZ_WORD, i, 0, e, r); chk(r, ref_mem[i]);
    end
    acc(5'h04, 2'b00, 5, 0, e, r); chk(e, 1'b1);
    axr(REG_CORE, r, rs); chk(r[CORE_WREJ], 1'b1);
    axr(REG_CORE, r, rs); chk(r[CORE_WREJ], 1'b0);
    acc(5'h00, 2'b00, 5, 0, e, r); chk(r, 32'hFFFFFFFF);
    acc(5'h06, SZ_WORD, 1, 0, e, r); chk(e, 1'b1);
    sys_mem_information_pages <= 32'h10000000;
    acc(5'h10, SZ_WORD, 0, 0, e, r); chk(r, 32'h0);
    acc(5'h14, SZ_WORD, 1, 0, e, r); chk(e, 1'b1);
    acc(5'h00, SZ_WORD, 1, 0, e, r); chk(r, ref_mem[1]);
    sys_mem_information_pages <= 0;
    axr(REG_LOAD_ST, r, rs);
    axw(REG_IRQ_EN, 32'h10);
    flip <= 39'h1;
    acc(5'h00, SZ_WORD, 2, 0, e, r); chk(r, ref_mem[2]);
    chk(irq, 1'b1);
    axr(REG_LOAD_ST, r, rs); chk(r[2:0], 3'h1);
    chk(irq, 1'b0);
    flip <= 39'h3;
    acc(5'h08, SZ_WORD, 3, 0, e, r); chk(e, 1'b1);
    chk(nmi_fetch_uncorr, 1'b1);
    axr(REG_FETCH_ADR, r, rs); chk(r, 32'h3);
    // Empty load raises the interrupt once its enable is set
    flip <= 39'h0;
    axw(REG_IRQ_EN, 32'h20);
    acc(5'h00, SZ_WORD, 9, 0, e, r); chk(r, 32'hFFFFFFFF);
    chk(irq, 1'b1);
    axr(REG_LOAD_ST, r, rs); chk(r[2:0], 3'h2);
    // Allow flag lets a locked debug read through until cleared
    @(posedge clk_sys);
    sys_mem_information_pages <= 32'h10000000;
    allow_set <= 3'h4;
    @(posedge clk_sys);
    allow_set <= 3'h0;
    acc(5'h10, SZ_WORD, 1, 0, e, r); chk(r, ref_mem[1]);
    axr(REG_CORE, r, rs); chk(r[7:5], 3'h4);
    axw(REG_CORE, 32'h100);
    axw(REG_EXEC, {24'h000000, CMD_SET_KEY});
    axr(REG_CORE, r, rs); chk(r, 32'h2);
    // Permitted command: one launch pulse, busy until done
    axw(REG_EXEC, {16'h0000, 8'h03, CMD_ERASE_PROG});
    chk(starts, 1);
    chk(cmd_code, CMD_ERASE_PROG);
    chk(cmd_page, 8'h03);
    axr(REG_CORE, r, rs); chk(r[CORE_BUSY], 1'b1);
    @(posedge clk_sys);
    cmd_done <= 1'b1;
    @(posedge clk_sys);
    cmd_done <= 1'b0;
    axr(REG_CORE, r, rs); chk(r, 32'h1);
    test_done();
  end
endmodule // fap_flash_access_tb

// [testbench/fap_flash_model.sv]
// Behavioural flash array on the far side of the access front end
`timescale 1ns/1ps
module fap_flash_model (
  // Clock
  input wire logic clk_sys,
  // Array port
  input wire logic fl_en,
  input wire logic fl_we,
  input wire logic [14:0] fl_addr,
  input wire logic [38:0] fl_wdata,
  input wire logic [38:0] flip,
  output logic [38:0] fl_rdata
);
  logic [38:0] mem [0:63];
  // Erased cells read as all ones
  initial for (int i = 0; i < 64; i++) mem[i] = '1;
  // Code word stored whole, check bits included
  always @(posedge clk_sys) if (fl_en && fl_we) mem[fl_addr[5:0]] <= fl_wdata;
  // Idle bus toggles so a stale word is never mistaken for data
  assign fl_rdata = fl_en ? mem[fl_addr[5:0]] ^ flip : {39{clk_sys}};
endmodule // fap_flash_model
